/* File: core/wdog_pkg.sv */
package wdog_pkg;
	// clock rate
	localparam int unsigned CLK_MHZ         = 125;
	// least trigger pulse width, microseconds
	localparam int unsigned TRIG_MIN_US     = 100;
	localparam int unsigned TRIG_MIN_CYC    = TRIG_MIN_US * CLK_MHZ;
	localparam int unsigned TRIG_CNT_W      = 14;
	// window lengths are programmed in units of this many cycles
	localparam int unsigned WIN_TICK_CYC    = 1000;
	localparam int unsigned TICK_CNT_W      = 10;
	localparam int unsigned WIN_W           = 8;
	// reset pulse length in ticks
	localparam logic [WIN_W-1:0] RST_PULSE_TICKS = 8'h0A;
	// monitor count: step-down a, step-down b, boost, analog, rail a, rail b
	localparam int unsigned MON_N           = 6;

	// window lengths and expiry action
	typedef struct packed {
		logic [WIN_W-1:0] long_open;
		logic [WIN_W-1:0] close_len;
		logic [WIN_W-1:0] open_len;
		logic             stay_in_reset;
	} wdog_cfg_t;

	// supervisor configuration
	typedef struct packed {
		logic [MON_N-1:0] mon_enable;
		logic [MON_N-1:0] to_primary;
		logic [MON_N-1:0] to_secondary;
		logic [MON_N-1:0] irq_mask;
		logic             window_sel;
		logic             sec_is_gpo;
		logic             gpo_level;
	} mon_cfg_t;

	// comparator results per monitor
	typedef struct packed {
		logic [MON_N-1:0] under;
		logic [MON_N-1:0] over;
	} mon_raw_t;

	typedef enum logic [2:0] {
		WD_OFF, WD_LONG_OPEN, WD_CLOSE, WD_OPEN, WATCHDOG_RESET_OUTPUT_PULSE, WD_HOLD
	} wd_state_t;
endpackage

/* File: core/window_watchdog_powergood_monitor.sv */
`timescale 1ns/1ps
// What this block does
// - trigger pulses shorter than 100 us ignored
// - every expiry produces reset output pulse
// - post-expiry action selectable by configuration
// - three window lengths independently configurable
// - long-open or open timeout enters reset
// - trigger during close window enters reset
// - control register write extends long-open
// - each monitored signal has own enable
// - window select 0 undervoltage, 1 both
// - one window select for all monitors
// - enabled results drive power-good outputs, interrupt
// - power-good interrupt per-flag maskable
// - secondary output shared with general output
// - configuration target at all bus rates
module window_watchdog_powergood_monitor (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              reset_n,
	// watchdog pin and configuration, plain ports so any bus rate serves
	input  wire logic              watchdog_trigger_input,
	input  wire logic              wd_enable,
	input  wire wdog_pkg::wdog_cfg_t wd_cfg,
	input  wire logic              ctrl_first_write,
	input  wire logic              ctrl_second_write,
	input  wire logic              wd_restart,
	output logic                   watchdog_reset_output,
	output logic                   wd_expired_flag,
	output logic [2:0]             wd_state_out,
	// supply monitor
	input  wire wdog_pkg::mon_raw_t mon_raw,
	input  wire wdog_pkg::mon_cfg_t supply_monitor_enable_reg,
	output logic                   supply_ok_out_primary,
	output logic                   supply_ok_out_secondary,
	output logic                   supply_irq,
	output logic [5:0]             mon_fault_status
);
	import wdog_pkg::*;

	// reset release synchroniser
	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// trigger pin synchroniser
	logic trig_meta;
	logic trig_sync;
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
		end else begin
			trig_meta <= watchdog_trigger_input;
			trig_sync <= trig_meta;
		end
	end

	// monitor input synchronisers
	mon_raw_t mon_meta;
	mon_raw_t mon_sync;
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mon_meta <= '0;
			mon_sync <= '0;
		end else begin
			mon_meta <= mon_raw;
			mon_sync <= mon_meta;
		end
	end

	// pulse width qualifier state
	logic [TRIG_CNT_W-1:0] width_cnt;      // high-time counter
	logic                  width_done;     // pulse already accepted
	logic [TRIG_CNT_W-1:0] next_width_cnt;
	logic                  next_width_done;
	logic                  trig_valid;     // one cycle when pulse qualifies

	// count high time; accept once at the minimum width
	always_comb begin
		next_width_cnt  = width_cnt;
		next_width_done = width_done;
		trig_valid      = 1'b0;
		if (!trig_sync) begin
			next_width_cnt  = '0;
			next_width_done = 1'b0;
		end else if (!width_done) begin
			if (width_cnt == TRIG_CNT_W'(TRIG_MIN_CYC - 1)) begin
				trig_valid      = 1'b1;
				next_width_done = 1'b1;
			end else begin
				next_width_cnt = width_cnt + 1'b1;
			end
		end
	end

	// register qualifier
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			width_cnt  <= '0;
			width_done <= 1'b0;
		end else begin
			width_cnt  <= next_width_cnt;
			width_done <= next_width_done;
		end
	end

	// watchdog state
	wd_state_t             state;
	logic [TICK_CNT_W-1:0] tick_cnt;   // prescaler
	logic [WIN_W-1:0]      win_cnt;    // ticks elapsed in window
	logic                  rst_out;
	logic                  exp_flag;
	wd_state_t             next_state;
	logic [TICK_CNT_W-1:0] next_tick_cnt;
	logic [WIN_W-1:0]      next_win_cnt;
	logic                  next_rst_out;
	logic                  next_exp_flag;
	logic                  tick;       // prescaler wrap
	logic [WIN_W-1:0]      win_len;    // length of current window
	logic                  win_end;    // current window elapsed

	// window sequencing
	always_comb begin
		next_state    = state;
		next_tick_cnt = tick_cnt + 1'b1;
		next_win_cnt  = win_cnt;
		next_rst_out  = 1'b0;
		next_exp_flag = exp_flag;
		tick          = (tick_cnt == TICK_CNT_W'(WIN_TICK_CYC - 1));
		// pick the length of the running window
		unique case (state)
			WD_LONG_OPEN:   win_len = wd_cfg.long_open;
			WD_CLOSE:       win_len = wd_cfg.close_len;
			WD_OPEN:        win_len = wd_cfg.open_len;
			WATCHDOG_RESET_OUTPUT_PULSE: win_len = RST_PULSE_TICKS;
			default:        win_len = '0;
		endcase
		win_end = tick && (win_cnt + 1'b1 >= win_len);
		if (tick) begin
			next_tick_cnt = '0;
			next_win_cnt  = win_cnt + 1'b1;
		end
		unique case (state)
			// idle until software enables
			WD_OFF: begin
				next_tick_cnt = '0;
				next_win_cnt  = '0;
				if (wd_enable) begin
					next_state = WD_LONG_OPEN;
				end
			end
			// first window after enable
			WD_LONG_OPEN: begin
				if (ctrl_first_write || ctrl_second_write) begin
					next_tick_cnt = '0;
					next_win_cnt  = '0;
				end else if (trig_valid) begin
					next_state    = WD_CLOSE;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
				end else if (win_end) begin
					next_state    = WATCHDOG_RESET_OUTPUT_PULSE;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
					next_exp_flag = 1'b1;
				end
			end
			// early trigger is a fault
			WD_CLOSE: begin
				next_tick_cnt = win_end ? '0 : next_tick_cnt;
				next_win_cnt  = win_end ? '0 : next_win_cnt;
				if (trig_valid) begin
					next_state    = WATCHDOG_RESET_OUTPUT_PULSE;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
					next_exp_flag = 1'b1;
				end else if (win_end) begin
					next_state = WD_OPEN;
				end
			end
			// trigger expected here
			WD_OPEN: begin
				if (trig_valid) begin
					next_state    = WD_CLOSE;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
				end else if (win_end) begin
					next_state    = WATCHDOG_RESET_OUTPUT_PULSE;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
					next_exp_flag = 1'b1;
				end
			end
			// reset output driven on every expiry
			WATCHDOG_RESET_OUTPUT_PULSE: begin
				next_rst_out = 1'b1;
				if (win_end) begin
					next_rst_out  = 1'b0;
					next_tick_cnt = '0;
					next_win_cnt  = '0;
					// configured follow-up action
					next_state    = wd_cfg.stay_in_reset ? WD_HOLD : WD_LONG_OPEN;
				end
			end
			// wait for software restart
			WD_HOLD: begin
				next_tick_cnt = '0;
				next_win_cnt  = '0;
				if (wd_restart) begin
					next_state    = WD_LONG_OPEN;
					next_exp_flag = 1'b0;
				end
			end
		endcase
		// disable overrides state and reset output, but not the expired flag
		if (!wd_enable) begin
			next_state   = WD_OFF;
			next_rst_out = 1'b0;
		end
		// new expiry wins over the clear only while the flag is clear; with the flag already set, restart clears it
		if (wd_restart && !(next_exp_flag && !exp_flag)) begin
			next_exp_flag = 1'b0; // restart clears in any state
		end
	end

	// register watchdog
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state    <= WD_OFF;
			tick_cnt <= '0;
			win_cnt  <= '0;
			rst_out  <= 1'b0;
			exp_flag <= 1'b0;
		end else begin
			state    <= next_state;
			tick_cnt <= next_tick_cnt;
			win_cnt  <= next_win_cnt;
			rst_out  <= next_rst_out;
			exp_flag <= next_exp_flag;
		end
	end

	// supervisor state
	logic [MON_N-1:0] fault;
	logic             pg_pri;
	logic             pg_sec;
	logic             irq;
	logic [MON_N-1:0] next_fault;
	logic             next_pg_pri;
	logic             next_pg_sec;
	logic             next_irq;

	// combine enabled monitor results
	always_comb begin
		// common window select for all monitors
		next_fault = supply_monitor_enable_reg.mon_enable & (mon_sync.under |
			(supply_monitor_enable_reg.window_sel ? mon_sync.over : '0));
		next_pg_pri = ~|(next_fault & supply_monitor_enable_reg.to_primary);
		// pin is power-good or plain output
		next_pg_sec = supply_monitor_enable_reg.sec_is_gpo ?
			supply_monitor_enable_reg.gpo_level :
			~|(next_fault & supply_monitor_enable_reg.to_secondary);
		next_irq = |(next_fault & ~supply_monitor_enable_reg.irq_mask);
	end

	// register supervisor outputs
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fault  <= '0;
			pg_pri <= 1'b0;
			pg_sec <= 1'b0;
			irq    <= 1'b0;
		end else begin
			fault  <= next_fault;
			pg_pri <= next_pg_pri;
			pg_sec <= next_pg_sec;
			irq    <= next_irq;
		end
	end

	// outputs straight from flops
	assign watchdog_reset_output   = rst_out;
	assign wd_expired_flag         = exp_flag;
	assign wd_state_out            = state;
	assign supply_ok_out_primary   = pg_pri;
	assign supply_ok_out_secondary = pg_sec;
	assign supply_irq              = irq;
	assign mon_fault_status        = fault;
endmodule

/* File: tb/wdog_checker.sv */
`timescale 1ns/1ps
module wdog_checker (
	// clock and reset
	input wire logic                 mclk,
	input wire logic                 reset_n,
	// watchdog side
	input wire logic                 wd_enable,
	input wire logic                 watchdog_reset_output,
	input wire logic                 wd_expired_flag,
	input wire logic [2:0]           wd_state_out,
	// supervisor side
	input wire wdog_pkg::mon_cfg_t   supply_monitor_enable_reg,
	input wire logic                 supply_ok_out_primary,
	input wire logic                 supply_ok_out_secondary,
	input wire logic                 supply_irq,
	input wire logic [5:0]           mon_fault_status
);
	import wdog_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [3:0] age;      // cycles since reset, saturating
	logic [3:0] next_age; // next count
	logic       up;       // pipeline settled after reset
	// age counter, keeps settle-time checks away from reset release
	always_comb begin
		next_age = (age == 4'hF) ? age : age + 4'h1;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			age <= 4'h0;
		end else begin
			age <= next_age;
		end
	end
	assign up = (age == 4'hF);
	chk_expiry_pulse: assert property (
		wd_state_out == WATCHDOG_RESET_OUTPUT_PULSE && $past(wd_state_out) != WATCHDOG_RESET_OUTPUT_PULSE
		|=> watchdog_reset_output) else $error("no reset pulse on expiry");
	chk_expiry_flag: assert property (
		wd_state_out == WATCHDOG_RESET_OUTPUT_PULSE && $past(wd_state_out) != WATCHDOG_RESET_OUTPUT_PULSE
		|=> wd_expired_flag) else $error("expired flag not set");
	chk_close_exit: assert property (
		wd_state_out == WD_CLOSE |=> wd_state_out inside {WD_OFF, WD_CLOSE, WD_OPEN,
		WATCHDOG_RESET_OUTPUT_PULSE}) else $error("bad exit from close window");
	chk_open_exit: assert property (
		wd_state_out == WD_OPEN |=> wd_state_out inside {WD_OFF, WD_CLOSE, WD_OPEN,
		WATCHDOG_RESET_OUTPUT_PULSE}) else $error("bad exit from open window");
	chk_disable_off: assert property (
		(!wd_enable) [*3] |-> wd_state_out == WD_OFF) else $error("not off when disabled");
	chk_irq_masked: assert property (
		(up && &supply_monitor_enable_reg.irq_mask) [*4] |-> !supply_irq)
		else $error("masked interrupt raised");
	chk_gpo_level: assert property (
		(up && supply_monitor_enable_reg.sec_is_gpo && supply_monitor_enable_reg.gpo_level) [*4]
		|-> supply_ok_out_secondary) else $error("general output level lost");
	chk_none_enabled: assert property (
		(up && supply_monitor_enable_reg.mon_enable == 6'h00) [*4]
		|-> supply_ok_out_primary && mon_fault_status == 6'h00) else $error("fault while disabled");
endmodule

/* File: tb/host_feeder.sv */
`timescale 1ns/1ps
module host_feeder (
	// clock
	input wire logic        mclk,
	// bench command
	input wire logic        start,
	input wire logic [15:0] len,
	// trigger pin and state
	output logic            watchdog_trigger_input,
	output logic            busy
);
	int cnt; // cycles left high
	initial begin
		watchdog_trigger_input = 1'b0;
		busy = 1'b0;
		cnt = 0;
	end
	// drives one high pulse of len cycles on command, idles low
	always @(posedge mclk) begin
		if (start && !busy) begin
			watchdog_trigger_input <= 1'b1;
			busy <= 1'b1;
			cnt <= len;
		end else if (busy) begin
			if (cnt <= 1) begin
				watchdog_trigger_input <= 1'b0;
				busy <= 1'b0;
			end
			cnt <= cnt - 1;
		end
	end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import wdog_pkg::*;
	logic mclk = 0, reset_n = 0, wd_enable = 0, wr1 = 0, wr2 = 0, wd_restart = 0;
	logic trig, busy, start = 0, rst_out, flag, ok_p, ok_s, irq;
	logic [15:0] len = 0;
	logic [2:0]  st;
	logic [5:0]  fault;
	wdog_cfg_t   wcfg = '0;
	mon_cfg_t    scfg = '0;
	mon_raw_t    raw = '0;
	int bad_count = 0, check_count = 0, seed = 8920, v;
	always #4 mclk = ~mclk;
	host_feeder HOST (.mclk(mclk), .start(start), .len(len),
		.watchdog_trigger_input(trig), .busy(busy));
	window_watchdog_powergood_monitor DUT (.mclk(mclk), .reset_n(reset_n),
		.watchdog_trigger_input(trig), .wd_enable(wd_enable), .wd_cfg(wcfg),
		.ctrl_first_write(wr1), .ctrl_second_write(wr2), .wd_restart(wd_restart),
		.watchdog_reset_output(rst_out), .wd_expired_flag(flag), .wd_state_out(st),
		.mon_raw(raw), .supply_monitor_enable_reg(scfg), .supply_ok_out_primary(ok_p),
		.supply_ok_out_secondary(ok_s), .supply_irq(irq), .mon_fault_status(fault));
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tally(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic cmp_st(input logic [2:0] a, input logic [2:0] e);
		tally(a === e, $sformatf("state %0d exp %0d", a, e));
	endtask
	task automatic cmp_pin(input logic a, input logic e);
		tally(a === e, "watchdog pin mismatch");
	endtask
	task automatic cmp_mon(input logic [8:0] a, input logic [8:0] e);
		tally(a === e, $sformatf("monitor %h exp %h", a, e));
	endtask
	// behavioural supervisor: one window mode for every enabled monitor
	function automatic logic [8:0] mon_exp(mon_raw_t r, mon_cfg_t c);
		logic [5:0] f;
		f = c.mon_enable & (r.under | (r.over & {6{c.window_sel}}));
		return {~|(f & c.to_primary), c.sec_is_gpo ? c.gpo_level : ~|(f & c.to_secondary),
			|(f & ~c.irq_mask), f};
	endfunction
	task automatic wait_st(input logic [2:0] e, input int lim);
		int n;
		n = 0;
		// always look at the state on a falling edge, never in the launch step
		do begin
			@(negedge mclk);
			n++;
		end while (st !== e && n < lim);
		cmp_st(st, e);
		if (st !== e) wrap_up();
	endtask
	task automatic pulse(input int n);
		int w;
		w = 0;
		// feeder must be idle and the pin low again before a new pulse
		while (busy && w < 20000) begin
			@(posedge mclk);
			w++;
		end
		if (busy) begin
			tally(1'b0, "feeder never idle");
			wrap_up();
		end
		start <= 1'b1;
		len <= n[15:0];
		@(posedge mclk);
		start <= 1'b0;
	endtask
	task automatic mon_step(input mon_cfg_t c);
		@(posedge mclk);
		v = $random(seed);
		raw <= v[11:0];
		scfg <= c;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		cmp_mon({ok_p, ok_s, irq, fault}, mon_exp(raw, scfg));
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// random monitor results and routing, then fixed corner cases
		for (int i = 0; i < 24; i++) mon_step(mon_cfg_t'($random(seed)));
		mon_step({6'h00, 6'h3F, 6'h3F, 6'h3F, 1'b1, 1'b1, 1'b1});
		mon_step({6'h3F, 6'h3F, 6'h00, 6'h00, 1'b0, 1'b0, 1'b0});
		// watchdog: enable, short pulse ignored, writes extend long-open
		@(posedge mclk);
		wcfg <= '{long_open: 8'h14, close_len: 8'h02, open_len: 8'h14, stay_in_reset: 1'b0};
		wd_enable <= 1'b1;
		wait_st(WD_LONG_OPEN, 5);
		pulse(1000);
		repeat (2000) @(posedge mclk);
		wr2 <= 1'b1;
		@(posedge mclk);
		wr2 <= 1'b0;
		repeat (13000) @(posedge mclk);
		wr1 <= 1'b1;
		@(posedge mclk);
		wr1 <= 1'b0;
		repeat (7200) @(posedge mclk);
		@(negedge mclk);
		cmp_st(st, WD_LONG_OPEN);
		pulse(12600);
		wait_st(WD_CLOSE, 12700);
		wait_st(WD_OPEN, 2020);
		@(posedge mclk);
		wcfg.close_len <= 8'h14;
		pulse(12600);
		wait_st(WD_CLOSE, 12700);
		pulse(12600);
		wait_st(WATCHDOG_RESET_OUTPUT_PULSE, 12700);
		@(posedge mclk);
		wcfg.long_open <= 8'h01;
		repeat (3) @(negedge mclk);
		cmp_pin(rst_out, 1'b1);
		cmp_pin(flag, 1'b1);
		wait_st(WD_LONG_OPEN, 10100);
		@(posedge mclk);
		wcfg.stay_in_reset <= 1'b1;
		wait_st(WATCHDOG_RESET_OUTPUT_PULSE, 1100);
		wait_st(WD_HOLD, 10100);
		cmp_pin(rst_out, 1'b0);
		@(posedge mclk);
		wd_restart <= 1'b1;
		@(posedge mclk);
		wd_restart <= 1'b0;
		repeat (4) @(negedge mclk);
		cmp_pin(flag, 1'b0);
		@(posedge mclk);
		wd_enable <= 1'b0;
		wait_st(WD_OFF, 5);
		wrap_up();
	end
endmodule

// checker sees only the ports of the design
bind window_watchdog_powergood_monitor wdog_checker CHK (.mclk(mclk), .reset_n(reset_n),
	.wd_enable(wd_enable), .watchdog_reset_output(watchdog_reset_output),
	.wd_expired_flag(wd_expired_flag), .wd_state_out(wd_state_out),
	.supply_monitor_enable_reg(supply_monitor_enable_reg),
	.supply_ok_out_primary(supply_ok_out_primary),
	.supply_ok_out_secondary(supply_ok_out_secondary), .supply_irq(supply_irq),
	.mon_fault_status(mon_fault_status));
